// ===== design/flash_card_params.svh
// Constants for the card power and ready register bank and its host controller
`ifndef FLASH_CARD_PARAMS_SVH
`define FLASH_CARD_PARAMS_SVH

`define GPD_ADDR          16'h4002
`define SLEEP_LO_ADDR     16'h4118
`define SLEEP_HI_ADDR     16'h411a
`define RDY_LO_ADDR       16'h4130
`define RDY_MID_ADDR      16'h4132
`define RDY_HI_ADDR       16'h4134
`define GPD_SLEEP_BIT     2
`define GPD_RESET         1'b0
`define SLEEP_RESET       8'h00
`define STATUS_READY      8'h80
`define MAX_DEVICES       20
`define MAX_PAIRS         10

`define CLK_MHZ           250
`define RECOVERY_TIME_NS  1000
`define RECOVERY_CYCLES   ((`RECOVERY_TIME_NS * `CLK_MHZ + 999) / 1000)

`define H_CTRL            4'h0
`define H_ADDR_LO         4'h1
`define H_ADDR_HI         4'h2
`define H_DATA            4'h3
`define H_CMD             4'h4
`define H_STATUS          4'h5
`define H_RESULT          4'h6
`define H_IRQ_STAT        4'h7
`define H_IRQ_MASK        4'h8
`define CTRL_CARD_ON_BIT  0
`define CMD_WR_BIT        0
`define CMD_RD_BIT        1
`define CMD_ATTR_BIT      2
`define IRQ_DONE_BIT      0
`define IRQ_REFUSED_BIT   1
`define IRQ_READY_BIT     2
`define IRQ_WIDTH         3

`endif

// ===== design/flash_card_pkg.sv
// Shared types of the card register bank and its host controller
package flash_card_pkg;
   typedef logic [15:0] card_addr_t;
   typedef logic [7:0]  card_byte_t;
   typedef enum logic [2:0] {
      H_IDLE    = 3'b001,
      H_STROBE  = 3'b010,
      H_CAPTURE = 3'b100
   } host_state_t;
endpackage

// ===== design/flash_card_link_if.sv
// Link between the host socket controller and the card register logic
`timescale 1ns/1ps
interface flash_card_link_if;
   import flash_card_pkg::*;
   logic       reg_sel_n;
   logic       ce1_n;
   logic       ce2_n;
   card_addr_t addr;
   card_byte_t wdata;
   logic       we;
   logic       oe;
   card_byte_t rdata;
   logic       rdy_bsy;
   modport host (output reg_sel_n, ce1_n, ce2_n, addr, wdata, we, oe, input rdata, rdy_bsy);
   modport card (input reg_sel_n, ce1_n, ce2_n, addr, wdata, we, oe, output rdata, rdy_bsy);
endinterface

// ===== design/ready_sync.sv
// Three-stage synchroniser with agreement filter for the device ready lines
`timescale 1ns/1ps
module ready_sync #(
   parameter int         WIDTH     = 20,
   parameter logic [0:0] RESET_LVL = 1'b1
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } sync_state_t;

   sync_state_t q_reg;
   sync_state_t q_next;

   generate
      if (WIDTH < 1) begin : g_bad
         $error("ready_sync width must be at least one");
      end
   endgenerate

   always_comb begin
      q_next    = q_reg;
      q_next.s1 = async_in;
      q_next.s2 = q_reg.s1;
      q_next.s3 = q_reg.s2;
      // A change is taken only once the two later stages agree
      for (int i = 0; i < WIDTH; i++) begin
         if (q_reg.s2[i] == q_reg.s3[i]) begin
            q_next.out[i] = q_reg.s3[i];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q_reg <= {4{{WIDTH{RESET_LVL}}}};
      end else begin
         q_reg <= q_next;
      end
   end

   assign sync_out = q_reg.out;
endmodule

// ===== design/flash_card_power_ready_regs.sv
// Card side: power-down, pair sleep and ready status registers with array gating
`timescale 1ns/1ps
`include "flash_card_params.svh"
module flash_card_power_ready_regs #(
   parameter int NUM_DEVICES = `MAX_DEVICES
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   flash_card_link_if.card             link,
   input  wire logic                   soft_restart_bit,
   input  wire logic [NUM_DEVICES-1:0] device_ready_line,
   input  wire flash_card_pkg::card_byte_t array_rdata,
   output logic      [NUM_DEVICES-1:0] device_sleep_input_n,
   output logic      [NUM_DEVICES-1:0] op_abort,
   output logic      [NUM_DEVICES-1:0] status_restore,
   output flash_card_pkg::card_byte_t  status_restore_value,
   output flash_card_pkg::card_addr_t  array_addr,
   output flash_card_pkg::card_byte_t  array_wdata,
   output logic                        array_we,
   output logic                        array_oe
);
   import flash_card_pkg::*;

   localparam int PAIRS = NUM_DEVICES / 2;

   typedef struct packed {
      logic                   glob;
      logic [PAIRS-1:0]       pair;
      card_byte_t             rdata;
      logic                   rdy_bsy;
      logic [NUM_DEVICES-1:0] sleep_n;
      logic [NUM_DEVICES-1:0] abort;
      logic [NUM_DEVICES-1:0] restore;
      card_byte_t             rvalue;
      card_addr_t             a_addr;
      card_byte_t             a_wdata;
      logic                   a_we;
      logic                   a_oe;
   } dev_state_t;

   dev_state_t                 q_reg;
   dev_state_t                 q_next;
   logic [NUM_DEVICES-1:0]     rdy_sync;
   logic [`MAX_DEVICES-1:0]    rdy_full;
   logic [`MAX_PAIRS-1:0]      pair_full;

   generate
      if (NUM_DEVICES < 2 || NUM_DEVICES > `MAX_DEVICES || (NUM_DEVICES % 2) != 0) begin : g_bad
         $error("NUM_DEVICES must be even and between 2 and 20");
      end
      if (`MAX_PAIRS * 2 != `MAX_DEVICES) begin : g_bad_map
         $error("register map pair and device counts disagree");
      end
   endgenerate

   ready_sync #(
      .WIDTH     (NUM_DEVICES),
      .RESET_LVL (1'b1)
   ) u_ready_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .async_in (device_ready_line),
      .sync_out (rdy_sync)
   );

   // Unfitted positions are filled in here so the decode sees a full card
   generate
      for (genvar i = 0; i < `MAX_DEVICES; i++) begin : g_rdy
         if (i < NUM_DEVICES) begin : g_fit
            assign rdy_full[i] = rdy_sync[i];
         end else begin : g_absent
            assign rdy_full[i] = 1'b1;
         end
      end
      for (genvar p = 0; p < `MAX_PAIRS; p++) begin : g_pair
         if (p < PAIRS) begin : g_fit
            assign pair_full[p] = q_reg.pair[p];
         end else begin : g_absent
            assign pair_full[p] = 1'b0;
         end
      end
   endgenerate

   function automatic card_byte_t reg_read(
      input card_addr_t              addr,
      input logic                    glob,
      input logic [`MAX_PAIRS-1:0]   pairs,
      input logic [`MAX_DEVICES-1:0] rdy
   );
      card_byte_t val;
      val = 8'h00;
      unique case (addr)
         `GPD_ADDR:      val[`GPD_SLEEP_BIT] = glob;
         `SLEEP_LO_ADDR: val = pairs[7:0];
         `SLEEP_HI_ADDR: val[1:0] = pairs[9:8];
         `RDY_LO_ADDR:   val = rdy[7:0];
         `RDY_MID_ADDR:  val = rdy[15:8];
         `RDY_HI_ADDR:   val[3:0] = rdy[19:16];
         default:        val = 8'h00;
      endcase
      return val;
   endfunction

   // A sleep register write replaces only the pair bits of the register it hits
   function automatic logic [`MAX_PAIRS-1:0] pairs_written(
      input card_addr_t            addr,
      input card_byte_t            wdata,
      input logic [`MAX_PAIRS-1:0] pairs
   );
      logic [`MAX_PAIRS-1:0] val;
      val = pairs;
      unique case (addr)
         `SLEEP_LO_ADDR: val[7:0] = wdata;
         `SLEEP_HI_ADDR: val[9:8] = wdata[1:0];
         default:        val = pairs;
      endcase
      return val;
   endfunction

   always_comb begin
      logic                  ce_on;
      logic                  reg_acc;
      logic                  arr_acc;
      logic [`MAX_PAIRS-1:0] pw;
      logic                  sl;
      ce_on   = 1'b0;
      reg_acc = 1'b0;
      arr_acc = 1'b0;
      pw      = pair_full;
      sl      = 1'b0;
      q_next  = q_reg;

      ce_on   = !(link.ce1_n && link.ce2_n);
      reg_acc = ce_on && !link.reg_sel_n;
      arr_acc = ce_on && link.reg_sel_n;

      // Global bit is stored on its own so clearing it keeps pair bits
      if (reg_acc && link.we) begin
         if (link.addr == `GPD_ADDR) begin
            q_next.glob = link.wdata[`GPD_SLEEP_BIT];
         end
         pw = pairs_written(link.addr, link.wdata, pair_full);
      end
      q_next.pair = pw[PAIRS-1:0];

      if (soft_restart_bit) begin
         q_next.glob = `GPD_RESET;
         q_next.pair = '0;
      end

      q_next.rdata = 8'h00;
      if (reg_acc && link.oe) begin
         q_next.rdata = reg_read(link.addr, q_reg.glob, pair_full, rdy_full);
      end else if (arr_acc && link.oe) begin
         q_next.rdata = array_rdata;
      end

      // Busy on any device pulls the shared pin to busy
      q_next.rdy_bsy = &rdy_full;

      for (int i = 0; i < NUM_DEVICES; i++) begin
         // Soft restart also holds the array asleep while it is active
         sl = q_next.glob || q_next.pair[i / 2] || soft_restart_bit;
         q_next.sleep_n[i] = !sl;
         q_next.abort[i]   = q_reg.sleep_n[i] && sl;
         q_next.restore[i] = !q_reg.sleep_n[i] && !sl;
      end
      q_next.rvalue = `STATUS_READY;

      // Address and data stay parked while the card is deselected
      q_next.a_we = 1'b0;
      q_next.a_oe = 1'b0;
      if (arr_acc) begin
         q_next.a_addr  = link.addr;
         q_next.a_wdata = link.wdata;
         q_next.a_we    = link.we;
         q_next.a_oe    = link.oe;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q_reg.glob    <= `GPD_RESET;
         q_reg.pair    <= '0;
         q_reg.rdata   <= 8'h00;
         q_reg.rdy_bsy <= 1'b1;
         q_reg.sleep_n <= '1;
         q_reg.abort   <= '0;
         q_reg.restore <= '0;
         q_reg.rvalue  <= `STATUS_READY;
         q_reg.a_addr  <= 16'h0000;
         q_reg.a_wdata <= 8'h00;
         q_reg.a_we    <= 1'b0;
         q_reg.a_oe    <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign link.rdata           = q_reg.rdata;
   assign link.rdy_bsy         = q_reg.rdy_bsy;
   assign device_sleep_input_n = q_reg.sleep_n;
   assign op_abort             = q_reg.abort;
   assign status_restore       = q_reg.restore;
   assign status_restore_value = q_reg.rvalue;
   assign array_addr           = q_reg.a_addr;
   assign array_wdata          = q_reg.a_wdata;
   assign array_we             = q_reg.a_we;
   assign array_oe             = q_reg.a_oe;
endmodule

// ===== design/flash_card_host.sv
// Host side: socket controller that issues card accesses and guards recovery time
`timescale 1ns/1ps
`include "flash_card_params.svh"
module flash_card_host #(
   parameter int RECOVERY_CYCLES = `RECOVERY_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   flash_card_link_if.host link,
   input  wire logic [3:0] sw_addr,
   input  wire logic [7:0] sw_wdata,
   input  wire logic       sw_wr,
   input  wire logic       sw_rd,
   output logic      [7:0] sw_rdata,
   output logic            irq
);
   import flash_card_pkg::*;

   localparam int RW = $clog2(RECOVERY_CYCLES + 1);

   typedef struct packed {
      host_state_t           state;
      logic                  card_on;
      card_addr_t            cmd_addr;
      card_byte_t            cmd_data;
      logic                  wake;
      card_byte_t            result;
      card_byte_t            rdata;
      logic [RW-1:0]         recov;
      logic [`IRQ_WIDTH-1:0] irq_stat;
      logic [`IRQ_WIDTH-1:0] irq_mask;
      logic                  irq;
      logic                  prev_rdy;
      logic                  reg_sel_n;
      logic                  ce_n;
      card_addr_t            addr;
      card_byte_t            wdata;
      logic                  we;
      logic                  oe;
   } host_st_t;

   host_st_t q_reg;
   host_st_t q_next;

   generate
      if (RECOVERY_CYCLES < 1) begin : g_bad
         $error("RECOVERY_CYCLES must be at least one");
      end
   endgenerate

   function automatic logic is_sleep_reg(input card_addr_t a);
      return (a == `SLEEP_LO_ADDR) || (a == `SLEEP_HI_ADDR);
   endfunction

   always_comb begin
      logic                  go_wr;
      logic                  go_rd;
      logic                  attr;
      logic                  pd_req;
      logic                  refuse;
      logic [`IRQ_WIDTH-1:0] ev;
      logic [`IRQ_WIDTH-1:0] clr;
      go_wr  = 1'b0;
      go_rd  = 1'b0;
      attr   = 1'b0;
      pd_req = 1'b0;
      refuse = 1'b0;
      ev     = '0;
      clr    = '0;
      q_next = q_reg;

      if (q_reg.recov != '0) begin
         q_next.recov = q_reg.recov - RW'(1);
      end

      if (sw_wr) begin
         unique case (sw_addr)
            `H_CTRL:     q_next.card_on = sw_wdata[`CTRL_CARD_ON_BIT];
            `H_ADDR_LO:  q_next.cmd_addr[7:0] = sw_wdata;
            `H_ADDR_HI:  q_next.cmd_addr[15:8] = sw_wdata;
            `H_DATA:     q_next.cmd_data = sw_wdata;
            `H_CMD: begin
               go_wr = sw_wdata[`CMD_WR_BIT];
               go_rd = sw_wdata[`CMD_RD_BIT] && !sw_wdata[`CMD_WR_BIT];
               attr  = sw_wdata[`CMD_ATTR_BIT];
            end
            `H_IRQ_STAT: clr = sw_wdata[`IRQ_WIDTH-1:0];
            `H_IRQ_MASK: q_next.irq_mask = sw_wdata[`IRQ_WIDTH-1:0];
            default:     q_next.card_on = q_reg.card_on;
         endcase
      end

      pd_req = attr && go_wr && (((q_reg.cmd_addr == `GPD_ADDR) && q_reg.cmd_data[`GPD_SLEEP_BIT])
               || (is_sleep_reg(q_reg.cmd_addr) && q_reg.cmd_data != 8'h00));
      refuse = (go_wr || go_rd) && (q_reg.state != H_IDLE || !q_reg.card_on
               || (!attr && q_reg.recov != '0)
               || (pd_req && !link.rdy_bsy));
      ev[`IRQ_REFUSED_BIT] = refuse;

      // Enables follow the card switch; address and data keep their last value
      q_next.ce_n = !q_next.card_on;
      q_next.we   = 1'b0;
      q_next.oe   = 1'b0;

      unique case (q_reg.state)
         H_IDLE: begin
            if ((go_wr || go_rd) && !refuse) begin
               q_next.addr      = q_reg.cmd_addr;
               q_next.wdata     = q_reg.cmd_data;
               q_next.reg_sel_n = !attr;
               q_next.we        = go_wr;
               q_next.oe        = go_rd;
               q_next.wake      = attr && go_wr && ((q_reg.cmd_addr == `GPD_ADDR) || is_sleep_reg(q_reg.cmd_addr));
               q_next.state     = H_STROBE;
            end
         end
         H_STROBE: begin
            if (q_reg.oe) begin
               q_next.state = H_CAPTURE;
            end else begin
               // Any wake-capable write restarts the wait, being conservative
               if (q_reg.wake) begin
                  q_next.recov = RW'(RECOVERY_CYCLES);
               end
               ev[`IRQ_DONE_BIT] = 1'b1;
               q_next.state      = H_IDLE;
            end
         end
         H_CAPTURE: begin
            q_next.result     = link.rdata;
            ev[`IRQ_DONE_BIT] = 1'b1;
            q_next.state      = H_IDLE;
         end
      endcase

      q_next.prev_rdy          = link.rdy_bsy;
      ev[`IRQ_READY_BIT]       = link.rdy_bsy && !q_reg.prev_rdy;
      q_next.irq_stat          = (q_reg.irq_stat & ~clr) | ev;
      q_next.irq               = |(q_next.irq_stat & q_next.irq_mask);

      q_next.rdata = 8'h00;
      if (sw_rd) begin
         unique case (sw_addr)
            `H_CTRL:     q_next.rdata[`CTRL_CARD_ON_BIT] = q_reg.card_on;
            `H_ADDR_LO:  q_next.rdata = q_reg.cmd_addr[7:0];
            `H_ADDR_HI:  q_next.rdata = q_reg.cmd_addr[15:8];
            `H_DATA:     q_next.rdata = q_reg.cmd_data;
            `H_STATUS:   q_next.rdata = {5'h00, link.rdy_bsy, q_reg.recov != '0, q_reg.state != H_IDLE};
            `H_RESULT:   q_next.rdata = q_reg.result;
            `H_IRQ_STAT: q_next.rdata[`IRQ_WIDTH-1:0] = q_reg.irq_stat;
            `H_IRQ_MASK: q_next.rdata[`IRQ_WIDTH-1:0] = q_reg.irq_mask;
            default:     q_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q_reg           <= '0;
         q_reg.state     <= H_IDLE;
         q_reg.prev_rdy  <= 1'b1;
         q_reg.reg_sel_n <= 1'b1;
         q_reg.ce_n      <= 1'b1;
      end else begin
         q_reg <= q_next;
      end
   end

   assign link.reg_sel_n = q_reg.reg_sel_n;
   assign link.ce1_n     = q_reg.ce_n;
   assign link.ce2_n     = q_reg.ce_n;
   assign link.addr      = q_reg.addr;
   assign link.wdata     = q_reg.wdata;
   assign link.we        = q_reg.we;
   assign link.oe        = q_reg.oe;
   assign sw_rdata       = q_reg.rdata;
   assign irq            = q_reg.irq;
endmodule

// ===== dv/flash_card_link_properties.sv
// Concurrent checks on the link between host controller and card
`timescale 1ns/1ps
module flash_card_link_properties #(
   parameter int RECOVERY_CYCLES = 250
) (
   input wire logic                       core_clk,
   input wire logic                       rst_n,
   input wire logic                       reg_sel_n,
   input wire logic                       ce1_n,
   input wire logic                       ce2_n,
   input wire flash_card_pkg::card_addr_t addr,
   input wire flash_card_pkg::card_byte_t wdata,
   input wire logic                       we,
   input wire logic                       oe,
   input wire flash_card_pkg::card_byte_t rdata,
   input wire logic                       rdy_bsy
);
   import flash_card_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic attr_rd;
   logic pd_wr;
   int   wait_cnt;
   assign attr_rd = oe && !reg_sel_n && !ce1_n;
   assign pd_wr   = we && !reg_sel_n && ((addr == 16'h4002 && wdata[2])
                    || ((addr == 16'h4118 || addr == 16'h411a) && wdata != 8'h00));
   // Any power register write restarts the window, so the check stays conservative
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wait_cnt <= 0;
      end else if (we && !reg_sel_n && (addr == 16'h4002 || addr == 16'h4118 || addr == 16'h411a)) begin
         wait_cnt <= RECOVERY_CYCLES - 1;
      end else if (wait_cnt != 0) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
   AST_CE_PAIR: assert property (ce1_n == ce2_n)
      else $error("card enables differ");
   AST_ENABLED_ACCESS: assert property ((we || oe) |-> !ce1_n && !ce2_n)
      else $error("strobe while card disabled");
   AST_ADDR_QUIET: assert property (ce1_n && $past(ce1_n) |-> $stable(addr) && $stable(wdata))
      else $error("address or data moved while disabled");
   AST_RDATA_IDLE: assert property (!$past(oe) |-> rdata == 8'h00)
      else $error("read data outside answer cycle");
   AST_READY_HIGH_RSVD: assert property (attr_rd && addr == 16'h4134 |=> rdata[7:4] == 4'h0)
      else $error("ready top byte reserved bits set");
   AST_SLEEP_HIGH_RSVD: assert property (attr_rd && addr == 16'h411a |=> rdata[7:2] == 6'h00)
      else $error("sleep high reserved bits set");
   AST_GLOBAL_RSVD: assert property (attr_rd && addr == 16'h4002 |=> (rdata & 8'hfb) == 8'h00)
      else $error("global register reserved bits set");
   AST_RECOVERY: assert property ((we || oe) && reg_sel_n |-> wait_cnt == 0)
      else $error("array access inside recovery");
   AST_PD_WHEN_READY: assert property (pd_wr |-> $past(rdy_bsy))
      else $error("power-down issued while a device was busy");
endmodule

// ===== dv/flash_card_power_ready_regs_test.sv
// Self-checking bench: host controller and full and reduced cards
`timescale 1ns/1ps
module flash_card_power_ready_regs_test;
   import flash_card_pkg::*;
   localparam int RC = 60;
   logic       core_clk, rst_n, sw_wr, sw_rd, irq, soft_restart_bit, array_we, array_oe, seen_clr;
   logic [3:0] sw_addr;
   logic [7:0] sw_wdata, sw_rdata, sw_rdata_s;
   logic [19:0] rdy_lines, sleep_n, op_abort, status_restore, abort_seen, restore_seen;
   card_byte_t array_rdata, restore_value, array_wdata;
   card_addr_t array_addr;
   logic [1:0] arr_seen;
   int         num_errors, n_tests;
   flash_card_link_if link();
   flash_card_link_if link_s();
   flash_card_host #(.RECOVERY_CYCLES(RC)) flash_card_host_i (.core_clk(core_clk), .rst_n(rst_n), .link(link),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
   flash_card_power_ready_regs #(.NUM_DEVICES(20)) flash_card_power_ready_regs_i (.core_clk(core_clk),
      .rst_n(rst_n), .link(link), .soft_restart_bit(soft_restart_bit), .device_ready_line(rdy_lines),
      .array_rdata(array_rdata), .device_sleep_input_n(sleep_n), .op_abort(op_abort),
      .status_restore(status_restore), .status_restore_value(restore_value), .array_addr(array_addr),
      .array_wdata(array_wdata), .array_we(array_we), .array_oe(array_oe));
   // Reduced card sees the same software traffic, so absent devices show up by comparison
   flash_card_host #(.RECOVERY_CYCLES(RC)) flash_card_host_small_i (.core_clk(core_clk), .rst_n(rst_n),
      .link(link_s), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata_s), .irq());
   flash_card_power_ready_regs #(.NUM_DEVICES(12)) flash_card_power_ready_regs_small_i (.core_clk(core_clk),
      .rst_n(rst_n), .link(link_s), .soft_restart_bit(soft_restart_bit), .device_ready_line(rdy_lines[11:0]),
      .array_rdata(array_rdata), .device_sleep_input_n(), .op_abort(), .status_restore(),
      .status_restore_value(), .array_addr(), .array_wdata(), .array_we(), .array_oe());
   flash_card_link_properties #(.RECOVERY_CYCLES(RC)) flash_card_link_properties_i (.core_clk(core_clk),
      .rst_n(rst_n), .reg_sel_n(link.reg_sel_n), .ce1_n(link.ce1_n), .ce2_n(link.ce2_n), .addr(link.addr),
      .wdata(link.wdata), .we(link.we), .oe(link.oe), .rdata(link.rdata), .rdy_bsy(link.rdy_bsy));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // Pulses last one cycle, so they are gathered here rather than sampled by the tasks
   always @(posedge core_clk) begin
      abort_seen <= seen_clr ? 20'h0 : abort_seen | op_abort;
      restore_seen <= seen_clr ? 20'h0 : restore_seen | status_restore;
      arr_seen <= seen_clr ? 2'b00 : arr_seen | {array_we, array_oe};
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge core_clk);
      sw_wr <= 1'b0;
   endtask
   task automatic sw_read(input logic [3:0] a, output logic [7:0] d, output logic [7:0] ds);
      @(posedge core_clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge core_clk);
      sw_rd <= 1'b0;
      #1;
      d = sw_rdata;
      ds = sw_rdata_s;
   endtask
   task automatic card_cmd(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d);
      logic [7:0] s, t;
      sw_write(4'h1, a[7:0]);
      sw_write(4'h2, a[15:8]);
      sw_write(4'h3, d);
      sw_write(4'h4, cmd);
      for (int i = 0; i < 20; i++) begin
         sw_read(4'h5, s, t);
         if (s[0] === 1'b0) return;
      end
      num_errors++;
      $display("MISMATCH at %0t: command never finished", $time);
      end_of_test();
   endtask
   task automatic card_read(input logic [15:0] a, output logic [7:0] d, output logic [7:0] ds);
      card_cmd(8'h06, a, 8'h00);
      sw_read(4'h6, d, ds);
   endtask
   function automatic logic [7:0] exp_ready(input logic [19:0] r, input int n, input int b);
      logic [23:0] v;
      v = {4'h0, r} | ~((24'h1 << n) - 24'h1);
      v[23:20] = 4'h0;
      return v[b*8 +: 8];
   endfunction
   function automatic logic [19:0] exp_sleep(input logic [9:0] p);
      logic [19:0] v;
      for (int i = 0; i < 20; i++) begin
         v[i] = ~p[i / 2];
      end
      return v;
   endfunction

   initial begin
      logic [7:0]  d, ds;
      logic [9:0]  p;
      logic [19:0] r, awake;
      logic [15:0] a;
      {sw_wr, sw_rd, soft_restart_bit, seen_clr, sw_addr, sw_wdata} = '0;
      rdy_lines = 20'hfffff;
      array_rdata = 8'h00;
      rst_n = 1'b0;
      num_errors = 0;
      n_tests = 0;
      d = 8'($urandom(73764));
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      sw_write(4'h0, 8'h01);
      sw_write(4'h8, 8'h02);
      card_read(16'h4118, d, ds);
      check({12'h0, d}, 20'h0);
      card_read(16'h411a, d, ds);
      check({12'h0, d}, 20'h0);
      check(sleep_n, 20'hfffff);
      $display("test reset_values done");
      for (int k = 0; k < 8; k++) begin
         r = (k == 0) ? 20'h0 : (k == 1) ? 20'hfffff : 20'($urandom);
         @(posedge core_clk);
         rdy_lines <= r;
         repeat (8) @(posedge core_clk);
         for (int b = 0; b < 3; b++) begin
            card_read(16'h4130 + 16'(2 * b), d, ds);
            check({12'h0, d}, {12'h0, exp_ready(r, 20, b)});
            check({12'h0, ds}, {12'h0, exp_ready(r, 12, b)});
         end
         check({19'h0, link.rdy_bsy}, {19'h0, &r});
      end
      rdy_lines <= 20'hfffff;
      repeat (8) @(posedge core_clk);
      $display("test ready_status done");
      sw_read(4'h7, d, ds);
      check({17'h0, d[2:0]}, 20'h5);
      p = 10'($urandom) | 10'h201;
      card_cmd(8'h05, 16'h4118, p[7:0]);
      card_cmd(8'h05, 16'h411a, {6'h3f, p[9:8]});
      settle();
      check(sleep_n, exp_sleep(p));
      card_read(16'h4118, d, ds);
      check({12'h0, d}, {12'h0, p[7:0]});
      check({12'h0, ds}, {14'h0, p[5:0]});
      card_read(16'h411a, d, ds);
      check({12'h0, d}, {18'h0, p[9:8]});
      check({12'h0, ds}, 20'h0);
      $display("test pair_sleep done");
      awake = exp_sleep(p);
      seen_clr <= 1'b1;
      @(posedge core_clk);
      seen_clr <= 1'b0;
      card_cmd(8'h05, 16'h4002, 8'hff);
      settle();
      check(sleep_n, 20'h0);
      check(abort_seen, awake);
      card_read(16'h4002, d, ds);
      check({12'h0, d}, 20'h4);
      seen_clr <= 1'b1;
      @(posedge core_clk);
      seen_clr <= 1'b0;
      card_cmd(8'h05, 16'h4002, 8'h00);
      card_cmd(8'h02, 16'h0123, 8'h00);
      sw_read(4'h7, d, ds);
      check({19'h0, d[1]}, 20'h1);
      check({19'h0, irq}, 20'h1);
      check({18'h0, arr_seen}, 20'h0);
      sw_write(4'h7, 8'h07);
      settle();
      check({19'h0, irq}, 20'h0);
      check(sleep_n, exp_sleep(p));
      check(restore_seen, awake);
      check({12'h0, restore_value}, 20'h80);
      card_read(16'h4118, d, ds);
      check({12'h0, d}, {12'h0, p[7:0]});
      repeat (RC) @(posedge core_clk);
      a = 16'($urandom);
      d = 8'($urandom);
      card_cmd(8'h01, a, d);
      check({4'h0, array_addr}, {4'h0, a});
      check({12'h0, array_wdata}, {12'h0, d});
      @(posedge core_clk);
      array_rdata <= 8'($urandom);
      card_cmd(8'h02, a, 8'h00);
      sw_read(4'h6, d, ds);
      check({12'h0, d}, {12'h0, array_rdata});
      check({18'h0, arr_seen}, 20'h3);
      $display("test global_power_down done");
      @(posedge core_clk);
      soft_restart_bit <= 1'b1;
      repeat (3) @(posedge core_clk);
      soft_restart_bit <= 1'b0;
      settle();
      card_read(16'h4118, d, ds);
      check({12'h0, d}, 20'h0);
      card_read(16'h411a, d, ds);
      check({12'h0, d}, 20'h0);
      check(sleep_n, 20'hfffff);
      $display("test soft_restart done");
      rdy_lines <= 20'hffffe;
      repeat (8) @(posedge core_clk);
      sw_write(4'h7, 8'h07);
      card_cmd(8'h05, 16'h4002, 8'h04);
      settle();
      check(sleep_n, 20'hfffff);
      check({19'h0, irq}, 20'h1);
      sw_read(4'h5, d, ds);
      check({19'h0, d[2]}, 20'h0);
      sw_write(4'h7, 8'h02);
      sw_write(4'h8, 8'h00);
      card_cmd(8'h05, 16'h4118, 8'h01);
      settle();
      check({19'h0, irq}, 20'h0);
      check(sleep_n, 20'hfffff);
      sw_read(4'h7, d, ds);
      check({19'h0, d[1]}, 20'h1);
      $display("test busy_refusal done");
      end_of_test();
   end
endmodule
